//--- dcat_top.sv
// Multi-channel DMA controller: channel arbiter and one AHB master.
// Assumes a single-layer AHB view with hready stretching every phase.
//
// Functional notes
// - Peripheral channels move each item under request then acknowledge handshake.
// - Memory-to-memory channel is pending as soon as it is enabled.
// - Arbitration is rerun after every single data item.
// - Item order: arbitration, address computation, read/write transfer, acknowledge.
// - Single-item block omits the final acknowledge step.
// - Arbitration plus address computation takes two cycles; wait states do not stretch it.
// - AHB peripheral read takes two cycles minimum, more when bus shared.
// - Memory write takes two cycles minimum, longer with wait states.
// - APB read takes two APB cycles plus bridge sync cycle.
// - When idle or after transfer, grant highest priority pending channel.
// - Peripheral-to-memory and memory-to-peripheral have identical service latency.
// - One channel: no new request until previous done; idle ack phase one cycle.
// - With several requests, arbitrate during last cycles of current access.
// - Two controllers on distinct slaves run in parallel without arbitration.
// - Bus matrix serves CPU first within round; round-robin bandwidth share.
// - While bridge completes an APB access, master port stays busy.
// - Concurrent CPU access to same APB adds four cycles latency.
// - Bus matrix grants the master one single word, then re-arbitrates.
// - Strict priority between channels; low priority may starve.
// - Each channel holds count, start address, width, increment per side.
`timescale 1ns/1ps
`include "dcat_map.svh"

module dcat_top
  import dcat_pkg::*;
#(
  parameter int NUM_CH = 7
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Channel setup
  input wire dcat_chan_cfg_t chan_cfg [NUM_CH],
  // Peripheral handshake
  input wire logic [NUM_CH-1:0] per_req,
  output logic [NUM_CH-1:0] per_ack_reg,
  // Status
  output logic [NUM_CH-1:0] block_done_reg,
  output logic xfer_error_reg,
  output logic busy_reg,
  output logic [$clog2(NUM_CH)-1:0] grant_id_reg,
  // AHB master port
  output dcat_ahb_req_t ahb_req_reg,
  input wire dcat_ahb_rsp_t ahb_rsp
);

  localparam int IDW = $clog2(NUM_CH);

  generate
    if (NUM_CH < 2 || NUM_CH > 16) begin : g_bad
      $error("dcat_top: NUM_CH must be 2 to 16");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Arbitration

  // Strict priority, ties to lower index
  function automatic logic [IDW-1:0] pick_winner(
    input logic [NUM_CH-1:0] pend,
    input dcat_chan_cfg_t cfg [NUM_CH]
  );
    logic [IDW-1:0] best;
    logic [`DCAT_PRIO_W-1:0] best_prio;
    logic found;
    best = '0;
    best_prio = '0;
    found = 1'b0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (pend[i] && (!found || cfg[i].prio >= best_prio)) begin
        best = IDW'(i);
        best_prio = cfg[i].prio;
        found = 1'b1;
      end
    end
    return best;
  endfunction : pick_winner

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  dcat_state_t state_reg;
  dcat_state_t state_next;
  logic [IDW-1:0] grant_reg;
  logic [`DCAT_CNT_W-1:0] idx_reg;
  logic [`DCAT_ADDR_W-1:0] dst_addr_reg;
  logic [`DCAT_DATA_W-1:0] data_reg;
  logic [NUM_CH-1:0] fresh_reg;
  logic [NUM_CH-1:0] complete_reg;
  logic [NUM_CH-1:0] hold_reg;
  logic [NUM_CH-1:0] pending;
  logic [`DCAT_CNT_W-1:0] ctx_rdata;
  logic [IDW-1:0] winner;
  logic any_pending;
  dcat_chan_cfg_t gcfg;
  logic [`DCAT_CNT_W-1:0] idx_now;
  logic [`DCAT_CNT_W-1:0] idx_inc;
  logic [`DCAT_ADDR_W-1:0] src_addr_now;
  logic [`DCAT_ADDR_W-1:0] dst_addr_now;
  logic hready;
  logic rd_done;
  logic wr_done;
  logic item_done;
  logic bus_err;
  logic last_item;
  logic need_ack;
  logic take_grant;

  ////////////////////////////////////////////////////////////////////////////
  // Pending requests and selection

  generate
    for (genvar i = 0; i < NUM_CH; i++) begin : g_pend
      // Finishing channel drops out of the back-to-back pick
      assign pending[i] = chan_cfg[i].enable && !complete_reg[i] && !hold_reg[i]
        && chan_cfg[i].count != `DCAT_IDX_ZERO
        && !(wr_done && grant_reg == IDW'(i) && (last_item || need_ack || ahb_rsp.hresp))
        && (chan_cfg[i].mem2mem || per_req[i]);
    end
  endgenerate

  assign any_pending = |pending;
  assign winner = pick_winner(pending, chan_cfg);
  assign gcfg = chan_cfg[grant_reg];

  ////////////////////////////////////////////////////////////////////////////
  // Handshake and bus status decode

  assign hready = ahb_rsp.hready;
  assign bus_err = ahb_rsp.hresp && hready && (state_reg == st_rdat || state_reg == st_wdat);
  assign rd_done = state_reg == st_rdat && hready;
  assign wr_done = state_reg == st_wdat && hready;
  assign item_done = wr_done && !ahb_rsp.hresp;
  assign idx_inc = idx_reg + `DCAT_IDX_ONE;
  assign last_item = idx_inc == gcfg.count;
  assign need_ack = !gcfg.mem2mem && gcfg.count != `DCAT_IDX_ONE;
  assign take_grant = state_reg == st_arb
    || ((wr_done || state_reg == st_ack) && any_pending);

  ////////////////////////////////////////////////////////////////////////////
  // Address computation

  assign idx_now = fresh_reg[grant_reg] ? `DCAT_IDX_ZERO : ctx_rdata;
  assign src_addr_now = gcfg.src_start
    + (gcfg.src_inc ? (`DCAT_ADDR_W'(idx_now) << gcfg.src_size) : '0);
  assign dst_addr_now = gcfg.dst_start
    + (gcfg.dst_inc ? (`DCAT_ADDR_W'(idx_now) << gcfg.dst_size) : '0);

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel item index store

  dcat_ctx_mem #(
    .WIDTH(`DCAT_CNT_W),
    .DEPTH(NUM_CH)
  ) u_ctx (
    .clock(clock),
    .we(item_done),
    .waddr(grant_reg),
    .wdata(idx_inc),
    .raddr(winner),
    .rdata_reg(ctx_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer next state

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      st_idle: begin
        if (any_pending) begin
          state_next = st_arb;
        end
      end
      st_arb: begin
        state_next = st_addr;
      end
      st_addr: begin
        state_next = st_radr;
      end
      st_radr: begin
        if (hready) begin
          state_next = st_rdat;
        end
      end
      st_rdat: begin
        if (bus_err) begin
          state_next = st_idle;
        end else if (hready) begin
          state_next = st_wadr;
        end
      end
      st_wadr: begin
        if (hready) begin
          state_next = st_wdat;
        end
      end
      st_wdat: begin
        if (!hready) begin
          state_next = st_wdat;
        end else if (!bus_err && need_ack) begin
          state_next = st_ack;
        end else if (any_pending) begin
          state_next = st_addr;
        end else begin
          state_next = st_idle;
        end
      end
      st_ack: begin
        if (any_pending) begin
          state_next = st_addr;
        end else begin
          state_next = st_idle;
        end
      end
      default: begin
        state_next = st_idle;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer registers

  always_ff @(posedge clock) begin
    if (reset) begin
      state_reg <= st_idle;
      busy_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      busy_reg <= state_next != st_idle;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      grant_reg <= '0;
      grant_id_reg <= '0;
    end else if (take_grant) begin
      grant_reg <= winner;
      grant_id_reg <= winner;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      idx_reg <= '0;
      dst_addr_reg <= '0;
    end else if (state_reg == st_addr) begin
      idx_reg <= idx_now;
      dst_addr_reg <= dst_addr_now;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      data_reg <= '0;
    end else if (rd_done) begin
      data_reg <= ahb_rsp.hrdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AHB master: single NONSEQ transfers only

  always_ff @(posedge clock) begin
    if (reset) begin
      ahb_req_reg.haddr <= '0;
      ahb_req_reg.htrans <= `DCAT_HTRANS_IDLE;
      ahb_req_reg.hwrite <= 1'b0;
      ahb_req_reg.hsize <= `DCAT_HSIZE_WORD;
      ahb_req_reg.hburst <= `DCAT_HBURST_SINGLE;
    end else begin
      ahb_req_reg.hburst <= `DCAT_HBURST_SINGLE;
      if (state_reg == st_addr) begin
        ahb_req_reg.haddr <= src_addr_now;
        ahb_req_reg.htrans <= `DCAT_HTRANS_NONSEQ;
        ahb_req_reg.hwrite <= 1'b0;
        ahb_req_reg.hsize <= gcfg.src_size;
      end else if (rd_done && !bus_err) begin
        ahb_req_reg.haddr <= dst_addr_reg;
        ahb_req_reg.htrans <= `DCAT_HTRANS_NONSEQ;
        ahb_req_reg.hwrite <= 1'b1;
        ahb_req_reg.hsize <= gcfg.dst_size;
      end else if ((state_reg == st_radr || state_reg == st_wadr) && hready) begin
        ahb_req_reg.htrans <= `DCAT_HTRANS_IDLE;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      ahb_req_reg.hwdata <= '0;
    end else if (state_reg == st_wadr && hready) begin
      ahb_req_reg.hwdata <= data_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel flags, acknowledge and completion

  generate
    for (genvar i = 0; i < NUM_CH; i++) begin : g_chan
      logic mine;
      assign mine = grant_reg == IDW'(i);

      always_ff @(posedge clock) begin
        if (reset) begin
          fresh_reg[i] <= 1'b1;
        end else if (!chan_cfg[i].enable) begin
          fresh_reg[i] <= 1'b1;
        end else if (item_done && mine) begin
          fresh_reg[i] <= 1'b0;
        end
      end

      always_ff @(posedge clock) begin
        if (reset) begin
          complete_reg[i] <= 1'b0;
        end else if (mine && ((item_done && last_item) || bus_err)) begin
          complete_reg[i] <= 1'b1;
        end else if (!chan_cfg[i].enable) begin
          complete_reg[i] <= 1'b0;
        end
      end

      // Held until the peripheral drops its request
      always_ff @(posedge clock) begin
        if (reset) begin
          hold_reg[i] <= 1'b0;
        end else if (item_done && mine && need_ack) begin
          hold_reg[i] <= 1'b1;
        end else if (!per_req[i]) begin
          hold_reg[i] <= 1'b0;
        end
      end

      always_ff @(posedge clock) begin
        if (reset) begin
          per_ack_reg[i] <= 1'b0;
          block_done_reg[i] <= 1'b0;
        end else begin
          per_ack_reg[i] <= item_done && mine && need_ack;
          block_done_reg[i] <= item_done && mine && last_item;
        end
      end
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (reset) begin
      xfer_error_reg <= 1'b0;
    end else begin
      xfer_error_reg <= bus_err;
    end
  end

endmodule : dcat_top

//--- dcat_map.svh
// Constants for the DMA channel arbiter and its AHB master.
// Assumes inclusion by the package and by the top module.
`ifndef DCAT_MAP_SVH
`define DCAT_MAP_SVH

// Field widths
`define DCAT_ADDR_W 32
`define DCAT_DATA_W 32
`define DCAT_CNT_W 16
`define DCAT_PRIO_W 2
`define DCAT_SIZE_W 3

// Item index values
`define DCAT_IDX_ZERO 16'h0000
`define DCAT_IDX_ONE 16'h0001

// AHB encodings
`define DCAT_HTRANS_IDLE 2'h0
`define DCAT_HTRANS_NONSEQ 2'h2
`define DCAT_HBURST_SINGLE 3'h0
`define DCAT_HSIZE_WORD 3'h2

// Sequencer state codes, Gray along the service path
`define DCAT_ST_IDLE 3'h0
`define DCAT_ST_ARB 3'h1
`define DCAT_ST_ADDR 3'h3
`define DCAT_ST_RADR 3'h2
`define DCAT_ST_RDAT 3'h6
`define DCAT_ST_WADR 3'h7
`define DCAT_ST_WDAT 3'h5
`define DCAT_ST_ACK 3'h4

`endif

//--- dcat_pkg.sv
// Types shared by the DMA channel arbiter files.
// Assumes dcat_map.svh is on the include path.
`include "dcat_map.svh"

package dcat_pkg;

  typedef enum logic [2:0] {
    st_idle = `DCAT_ST_IDLE,
    st_arb = `DCAT_ST_ARB,
    st_addr = `DCAT_ST_ADDR,
    st_radr = `DCAT_ST_RADR,
    st_rdat = `DCAT_ST_RDAT,
    st_wadr = `DCAT_ST_WADR,
    st_wdat = `DCAT_ST_WDAT,
    st_ack = `DCAT_ST_ACK
  } dcat_state_t;

  // Per-channel setup, source and destination each independent
  typedef struct packed {
    logic enable;
    logic mem2mem;
    logic [`DCAT_PRIO_W-1:0] prio;
    logic [`DCAT_CNT_W-1:0] count;
    logic [`DCAT_ADDR_W-1:0] src_start;
    logic [`DCAT_ADDR_W-1:0] dst_start;
    logic [`DCAT_SIZE_W-1:0] src_size;
    logic [`DCAT_SIZE_W-1:0] dst_size;
    logic src_inc;
    logic dst_inc;
  } dcat_chan_cfg_t;

  typedef struct packed {
    logic [`DCAT_ADDR_W-1:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [2:0] hburst;
    logic [`DCAT_DATA_W-1:0] hwdata;
  } dcat_ahb_req_t;

  typedef struct packed {
    logic [`DCAT_DATA_W-1:0] hrdata;
    logic hready;
    logic hresp;
  } dcat_ahb_rsp_t;

endpackage : dcat_pkg

//--- dcat_ctx_mem.sv
// Small per-channel context store with registered read data.
// Assumes one write and one read port on the same clock.
`timescale 1ns/1ps

module dcat_ctx_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 7
) (
  // Clock
  input wire logic clock,
  // Write port
  input wire logic we,
  input wire logic [$clog2(DEPTH)-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  // Read port
  input wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic [WIDTH-1:0] rdata_reg
);

  generate
    if (DEPTH < 2 || WIDTH < 1) begin : g_bad
      $error("dcat_ctx_mem: DEPTH must be at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];

  // Write-first so a same-cycle reread sees the new value
  always_ff @(posedge clock) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    if (we && waddr == raddr) begin
      rdata_reg <= wdata;
    end else begin
      rdata_reg <= mem[raddr];
    end
  end

endmodule : dcat_ctx_mem

//--- dcat_asserts.sv
// Port checks for the DMA channel arbiter and its AHB master.
// Assumes a bind into dcat_top, one clock, synchronous reset.
`timescale 1ns/1ps
`include "dcat_map.svh"

module dcat_asserts
  import dcat_pkg::*;
#(
  parameter int NUM_CH = 7
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Handshake and status
  input wire logic [NUM_CH-1:0] per_req,
  input wire logic [NUM_CH-1:0] per_ack_reg,
  input wire logic busy_reg,
  // AHB master port
  input wire dcat_ahb_req_t ahb_req_reg,
  input wire dcat_ahb_rsp_t ahb_rsp
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  logic nseq;
  assign nseq = ahb_req_reg.htrans == `DCAT_HTRANS_NONSEQ;
  ////////////////////////////////////////
  single_burst_a: assert property (ahb_req_reg.hburst == `DCAT_HBURST_SINGLE)
    else $error("burst not single");
  one_item_a: assert property (nseq && ahb_rsp.hready |=> !nseq)
    else $error("pipelined transfer");
  addr_hold_a: assert property (nseq && !ahb_rsp.hready |=> nseq && $stable(ahb_req_reg.haddr))
    else $error("address dropped in wait");
  arb_time_a: assert property ($rose(busy_reg) |-> !nseq ##1 !nseq)
    else $error("arbitration too short");
  idle_bus_a: assert property (!busy_reg |-> !nseq)
    else $error("transfer while idle");
  ack_cause_a: assert property (|per_ack_reg |-> (per_ack_reg & ~$past(per_req)) == '0)
    else $error("ack without request");
  ack_pulse_a: assert property (|per_ack_reg |-> $onehot(per_ack_reg) ##1 per_ack_reg == '0)
    else $error("ack not one pulse");
  ack_quiet_a: assert property (|per_ack_reg |-> !nseq)
    else $error("ack during transfer");
endmodule : dcat_asserts

bind dcat_top dcat_asserts #(.NUM_CH(NUM_CH)) i_dcat_asserts (.clock(clock), .reset(reset),
  .per_req(per_req), .per_ack_reg(per_ack_reg), .busy_reg(busy_reg), .ahb_req_reg(ahb_req_reg),
  .ahb_rsp(ahb_rsp));

//--- dcat_slave_model.sv
// AHB slave model: word memory, data phase wait states, one error address.
// Assumes a non-pipelined single-transfer master on the same clock.
`timescale 1ns/1ps

module dcat_slave_model
  import dcat_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Setup
  input wire logic [3:0] waits,
  input wire logic [31:0] err_addr,
  // AHB slave port
  input wire dcat_ahb_req_t ahb_req,
  output dcat_ahb_rsp_t ahb_rsp
);
  logic [31:0] mem [256];
  logic [31:0] a_reg;
  logic [31:0] junk_reg;
  logic [3:0] cnt_reg;
  logic ph_reg;
  logic wr_reg;
  logic last;
  ////////////////////////////////////////
  // Wait states model shared bus, bridge and CPU contention
  assign last = ph_reg && cnt_reg == waits;
  assign ahb_rsp.hready = !ph_reg || last;
  assign ahb_rsp.hresp = last && a_reg == err_addr;
  // Read data valid only at the end of a read phase
  assign ahb_rsp.hrdata = (last && !wr_reg) ? mem[a_reg[9:2]] : junk_reg;
  always @(posedge clock) begin
    if (reset) begin
      ph_reg <= 1'b0;
      cnt_reg <= 4'h0;
      junk_reg <= 32'h0000_0000;
    end else if (ph_reg && !last) begin
      cnt_reg <= cnt_reg + 4'h1;
      junk_reg <= {junk_reg[30:0], ~junk_reg[31]};
    end else begin
      if (last && wr_reg && a_reg != err_addr) begin
        mem[a_reg[9:2]] <= ahb_req.hwdata;
      end
      ph_reg <= ahb_req.htrans[1];
      a_reg <= ahb_req.haddr;
      wr_reg <= ahb_req.hwrite;
      cnt_reg <= 4'h0;
      junk_reg <= {junk_reg[30:0], ~junk_reg[31]};
    end
  end
endmodule : dcat_slave_model

//--- dma_channel_arbiter_timing_tb.sv
// Self-checking bench for the DMA channel arbiter.
// Assumes dcat_pkg, the slave model and the bound checker are compiled.
`timescale 1ns/1ps
`include "dcat_map.svh"

module dma_channel_arbiter_timing_tb import dcat_pkg::*;;
  localparam int NCH = 4;
  logic clock;
  logic reset;
  dcat_chan_cfg_t cfg [NCH];
  logic [NCH-1:0] per_req;
  logic [NCH-1:0] per_ack;
  logic [NCH-1:0] done;
  logic busy;
  logic err;
  logic [1:0] gid;
  dcat_ahb_req_t req;
  dcat_ahb_rsp_t rsp;
  logic [3:0] waits;
  logic [31:0] err_addr;
  logic [31:0] ref_mem [256];
  logic [31:0] wq [$];
  logic [31:0] expq [$];
  int ord [3] = '{1, 2, 0};
  int seed = 32'h52f1_3d58;
  int n_mismatch;
  int num_checks;
  int n_ack;
  int n_done;
  int n_err;
  int i;
  int j;
  int d0;

  dcat_top #(.NUM_CH(NCH)) i_dcat_top (.clock(clock), .reset(reset), .chan_cfg(cfg),
    .per_req(per_req), .per_ack_reg(per_ack), .block_done_reg(done), .xfer_error_reg(err),
    .busy_reg(busy), .grant_id_reg(gid), .ahb_req_reg(req), .ahb_rsp(rsp));
  dcat_slave_model i_dcat_slave_model (.clock(clock), .reset(reset), .waits(waits),
    .err_addr(err_addr), .ahb_req(req), .ahb_rsp(rsp));
  ////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  always @(posedge clock) begin
    if (!reset) begin
      if (req.htrans == `DCAT_HTRANS_NONSEQ && req.hwrite && rsp.hready) wq.push_back(req.haddr);
      n_ack += $countones(per_ack);
      n_done += $countones(done);
      n_err += int'(err);
    end
  end

  task automatic chk(input bit ok, input string msg);
    num_checks++;
    if (!ok) begin
      n_mismatch++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask : chk

  task automatic set_ch(input int ch, input bit m2m, input int pr, cnt, input bit si, di);
    cfg[ch] <= '{1'b1, m2m, pr[1:0], cnt[15:0], 32'(ch * 64), 32'(512 + ch * 64),
      `DCAT_HSIZE_WORD, `DCAT_HSIZE_WORD, si, di};
  endtask : set_ch

  task automatic move(input int ch, k, input bit si, di);
    ref_mem[(512 + ch * 64 + (di ? 4 * k : 0)) / 4] = ref_mem[(ch * 64 + (si ? 4 * k : 0)) / 4];
  endtask : move

  task automatic per_block(input int ch, cnt, input bit si, di);
    int n;
    int w;
    int a0;
    w = $unsigned($random(seed)) % 4;
    @(posedge clock);
    waits <= w[3:0];
    set_ch(ch, 1'b0, 2, cnt, si, di);
    a0 = n_ack;
    for (int k = 0; k < cnt; k++) begin
      @(posedge clock);
      per_req[ch] <= 1'b1;
      for (n = 1; n < 100; n++) begin
        @(posedge clock);
        #1;
        if (per_ack[ch] === 1'b1 || done[ch] === 1'b1) break;
      end
      if (cnt > 1) chk(n == 7 + 2 * w && per_ack[ch] === 1'b1, "ack latency");
      chk(gid === 2'(ch), "grant id");
      move(ch, k, si, di);
      repeat (2) begin
        @(posedge clock);
        #1;
        chk(busy === 1'b0, "served while request held");
      end
      @(posedge clock);
      per_req[ch] <= 1'b0;
    end
    chk(n_ack == a0 + (cnt > 1 ? cnt : 0), "ack count");
  endtask : per_block

  task automatic tally_and_finish;
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    #100000;
    n_mismatch++;
    tally_and_finish();
  end
  ////////////////////////////////////////
  initial begin
    reset = 1'b1;
    per_req = '0;
    waits = 4'h0;
    err_addr = 32'hffff_ffff;
    for (i = 0; i < NCH; i++) cfg[i] = '0;
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    for (i = 0; i < 256; i++) begin
      ref_mem[i] = $random(seed);
      i_dcat_slave_model.mem[i] = ref_mem[i];
    end
    per_block(0, 3, 1'b1, 1'b1);
    per_block(1, 3, 1'b0, 1'b1);
    per_block(2, 3, 1'b1, 1'b0);
    per_block(3, 1, 1'b1, 1'b1);
    // Three software channels started together
    @(posedge clock);
    for (i = 0; i < NCH; i++) cfg[i] <= '0;
    @(posedge clock);
    wq.delete();
    waits <= 4'($unsigned($random(seed)) % 4);
    set_ch(0, 1'b1, 1, 2, 1'b1, 1'b1);
    set_ch(1, 1'b1, 3, 2, 1'b1, 1'b1);
    set_ch(2, 1'b1, 3, 2, 1'b1, 1'b1);
    d0 = n_done;
    for (i = 0; i < 3; i++) begin
      for (j = 0; j < 2; j++) begin
        expq.push_back(32'(512 + ord[i] * 64 + 4 * j));
        move(ord[i], j, 1'b1, 1'b1);
      end
    end
    for (i = 0; i < 500 && n_done < d0 + 3; i++) @(posedge clock);
    chk(n_done == d0 + 3 && wq.size() == 6, "software blocks");
    for (i = 0; i < 6; i++) chk(wq[i] === expq[i], "write order");
    // Bus error on the first read
    @(posedge clock);
    for (i = 0; i < NCH; i++) cfg[i] <= '0;
    err_addr <= 32'h0000_00c0;
    wq.delete();
    d0 = n_err;
    @(posedge clock);
    set_ch(3, 1'b1, 0, 2, 1'b1, 1'b1);
    for (i = 0; i < 200 && n_err == d0; i++) @(posedge clock);
    repeat (20) @(posedge clock);
    chk(n_err == d0 + 1 && wq.size() == 0, "error abort");
    for (i = 0; i < 256; i++) chk(i_dcat_slave_model.mem[i] === ref_mem[i], "memory word");
    tally_and_finish();
  end
endmodule : dma_channel_arbiter_timing_tb
